// *** include/spi_seq_params.svh ***
// constants for the serial master transfer sequencer
`ifndef SPI_SEQ_PARAMS_SVH
`define SPI_SEQ_PARAMS_SVH
`define WORD_W 32
`define SIZE_W 5
`define FRF_FOUR_WIRE 2'h0
`define FRF_THREE_WIRE 2'h2
`define ICR_OVR_BIT 0
`define ICR_UNR_BIT 1
`define CLK_PERIOD_NS 8
`define SCLK_HALF_NS 40
`define CNT_W_DEF 16
`endif

// *** include/spi_seq_pkg.sv ***
// types shared by the serial master transfer sequencer
package spi_seq_pkg;
  typedef enum logic [1:0] {MODE_FULL, MODE_TX_ONLY, MODE_RX_CNT, MODE_COMBINED} xfer_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_RESP, ST_GAP} seq_state_t;
  typedef enum logic [1:0] {CNT_NONE, CNT_TX, CNT_RX} cnt_owner_t;
  typedef struct packed {
    logic port_enable;
    logic master;
    xfer_mode_t transfer_mode_select;
    logic [1:0] frame_format;
    logic [4:0] command_size;
    logic [4:0] data_size;
    logic lsb_first;
    logic keep_clocking;
  } seq_cfg_t;
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic dout;
    logic dout_oe;
  } spi_pins_t;
  typedef struct packed {
    logic rx_overrun;
    logic tx_underrun;
    logic tx_empty;
  } irq_src_t;
endpackage

// *** src/spi_rx_buf.sv ***
// two-entry receive buffer with valid/ready on both sides
module spi_rx_buf #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0] cnt;
  } buf_st_t;
  buf_st_t s_q, s_d;
  logic push, pop;

  if (W < 1) begin : g_chk
    $error("spi_rx_buf: W must be positive");
  end

  assign in_ready_o = (s_q.cnt != 2'h2);
  assign out_valid_o = (s_q.cnt != 2'h0);
  assign out_data_o = s_q.d0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.d0 = s_q.d1;
    end
    if (push) begin
      // slot index is the count after the pop has been taken
      if ((s_q.cnt == 2'h0) || (s_q.cnt == 2'h1 && pop)) begin
        s_d.d0 = in_data_i;
      end else begin
        s_d.d1 = in_data_i;
      end
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// *** src/spi_master_seq.sv ***
// serial master transfer sequencer: modes, frame counters, error sources
// Overview of operation
// - rx full at word end: raise overrun, drop word, keep buffer; clear by write 1
// - mode 00/01 frame started with tx empty: raise underrun, resend stale word; clear by 1
// - tx empty source follows tx queue emptiness, drops once a word is present
// - mode 00: send tx words, store every received word
// - mode 01: send tx words whenever available, store nothing received
// - mode 10, tx empty: send dummy each frame, count rx counter down
// - mode 10, tx pending: send it without counting, then switch to dummy
// - mode 10 dummy sending stops at rx count zero; software reloads nonzero to resume
// - rx counter decrements with tx empty or during a mode 10 dummy run, before the word goes out
// - once dummy sending started, later tx words are ignored in mode 10 until the run ends at rx count zero
// - combined: tx count zero, rx count nonzero, tx empty: dummy, capture, count rx
// - combined: tx count per queue word, rx count per dummy, before sending
// - combined halts on three listed counter and queue conditions
// - a started counter is used to zero before the other one begins
// - every word sent in counted modes captures one word from the slave
// - mode may change while enabled; taken only at next word start
// - frame format 0 is four-wire, 2 is three-wire command/response
// - three-wire: shared line, command size out, data size in
// - three-wire transmit: send command, read response, then busy drops to mark the end
`include "spi_seq_params.svh"
module spi_master_seq import spi_seq_pkg::*; #(
  parameter int CNT_W = `CNT_W_DEF,
  parameter int HALF_CYC = (`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire seq_cfg_t CFG_I,
  input wire logic [`WORD_W-1:0] DUMMY_CHAR_I,
  input wire logic RXCNT_WR_I,
  input wire logic [CNT_W-1:0] RXCNT_I,
  input wire logic TXCNT_WR_I,
  input wire logic [CNT_W-1:0] TXCNT_I,
  input wire logic [1:0] INT_CLR_I,
  input wire logic TX_VALID_I,
  input wire logic [`WORD_W-1:0] TX_DATA_I,
  output logic TX_READY_O,
  output logic RX_VALID_O,
  input wire logic RX_READY_I,
  output logic [`WORD_W-1:0] RX_DATA_O,
  output logic [CNT_W-1:0] RXCNT_O,
  output logic [CNT_W-1:0] TXCNT_O,
  output irq_src_t IRQ_SRC_O,
  output logic BUSY_O,
  output spi_pins_t PINS_O,
  input wire logic DIN_I
);
  localparam int DIV_W = $clog2(HALF_CYC + 1);

  typedef struct packed {
    seq_state_t st;
    xfer_mode_t mode;
    logic capture;
    logic three;
    logic [CNT_W-1:0] rxcnt;
    logic [CNT_W-1:0] txcnt;
    cnt_owner_t owner;
    logic rx_dummy;
    logic [`WORD_W-1:0] txsh;
    logic [`WORD_W-1:0] rxsh;
    logic [`SIZE_W-1:0] bitn;
    logic [`SIZE_W-1:0] last;
    logic [DIV_W-1:0] div;
    logic [2:0] sync;
    logic din;
    logic push;
    logic ovr;
    logic unr;
    logic txe;
    spi_pins_t pins;
  } seq_st_t;

  seq_st_t s_q, s_d;
  logic start, use_tx, use_dummy, stale, drx, dtx, cap, fin, ovr_evt, buf_ready;
  logic half_tick, is_three;

  if (CNT_W < 1 || HALF_CYC < 1) begin : g_chk
    $error("spi_master_seq: CNT_W and HALF_CYC must be positive");
  end

  // position of serial bit cnt inside a word of last+1 bits
  function automatic logic [`SIZE_W-1:0] bit_idx(input logic [`SIZE_W-1:0] cnt,
                                                 input logic [`SIZE_W-1:0] last,
                                                 input logic lsb);
    return lsb ? cnt : `SIZE_W'(last - cnt);
  endfunction

  assign is_three = (CFG_I.frame_format == `FRF_THREE_WIRE);
  assign half_tick = (s_q.div == DIV_W'(HALF_CYC - 1));

  // word start decision; only sampled in idle so a mode write lands between words
  always_comb begin
    use_tx = 1'b0;
    use_dummy = 1'b0;
    stale = 1'b0;
    drx = 1'b0;
    dtx = 1'b0;
    cap = 1'b0;
    if (CFG_I.port_enable && CFG_I.master && s_q.st == ST_IDLE) begin
      if (is_three) begin
        use_tx = TX_VALID_I;
        cap = 1'b1;
      end else begin
        case (CFG_I.transfer_mode_select)
          MODE_FULL, MODE_TX_ONLY: begin
            use_tx = TX_VALID_I;
            stale = !TX_VALID_I && CFG_I.keep_clocking;
            cap = (CFG_I.transfer_mode_select == MODE_FULL);
          end
          MODE_RX_CNT: begin
            cap = 1'b1;
            if (!s_q.rx_dummy && TX_VALID_I) begin
              use_tx = 1'b1;
            end else if (s_q.rxcnt != '0) begin
              use_dummy = 1'b1;
              drx = 1'b1;
            end
          end
          MODE_COMBINED: begin
            cap = 1'b1;
            if (s_q.owner != CNT_RX && s_q.txcnt != '0) begin
              use_tx = TX_VALID_I;
              dtx = TX_VALID_I;
            end else if (s_q.owner != CNT_TX && s_q.rxcnt != '0 && !TX_VALID_I) begin
              use_dummy = 1'b1;
              drx = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign start = use_tx || use_dummy || stale;
  assign TX_READY_O = use_tx;
  assign fin = half_tick && s_q.pins.sclk && (s_q.bitn == s_q.last) &&
               (s_q.st == ST_RESP || (s_q.st == ST_SHIFT && !s_q.three));
  assign ovr_evt = fin && s_q.capture && !buf_ready;

  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    // first stage feeds only the second; a change counts once stages two and three agree
    s_d.sync = {s_q.sync[1:0], DIN_I};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.din = s_q.sync[2];
    end
    s_d.txe = !TX_VALID_I;
    case (s_q.st)
      ST_IDLE: begin
        s_d.pins.dout_oe = CFG_I.port_enable && !is_three;
        if (start) begin
          s_d.st = ST_SHIFT;
          s_d.mode = CFG_I.transfer_mode_select;
          s_d.three = is_three;
          s_d.capture = cap;
          // stale start leaves the old shift word in place
          s_d.txsh = use_tx ? TX_DATA_I : (use_dummy ? DUMMY_CHAR_I : s_q.txsh);
          s_d.rxsh = '0;
          s_d.bitn = '0;
          s_d.last = is_three ? CFG_I.command_size : CFG_I.data_size;
          s_d.div = '0;
          s_d.pins.cs_n = 1'b0;
          s_d.pins.sclk = 1'b0;
          s_d.pins.dout_oe = 1'b1;
          s_d.pins.dout = s_d.txsh[bit_idx('0, s_d.last, CFG_I.lsb_first)];
          if (drx) begin
            s_d.rxcnt = s_q.rxcnt - CNT_W'(1);
            s_d.rx_dummy = (CFG_I.transfer_mode_select == MODE_RX_CNT);
            s_d.owner = CNT_RX;
          end
          if (dtx) begin
            s_d.txcnt = s_q.txcnt - CNT_W'(1);
            s_d.owner = CNT_TX;
          end
        end
      end
      ST_SHIFT, ST_RESP: begin
        s_d.div = half_tick ? '0 : s_q.div + DIV_W'(1);
        if (half_tick) begin
          s_d.pins.sclk = !s_q.pins.sclk;
          if (!s_q.pins.sclk) begin
            s_d.rxsh[bit_idx(s_q.bitn, s_q.last, CFG_I.lsb_first)] = s_q.din;
          end else if (s_q.bitn != s_q.last) begin
            s_d.bitn = s_q.bitn + `SIZE_W'(1);
            s_d.pins.dout = s_q.txsh[bit_idx(s_d.bitn, s_q.last, CFG_I.lsb_first)];
          end else if (s_q.st == ST_SHIFT && s_q.three) begin
            // command done: release the shared line and read the response
            s_d.st = ST_RESP;
            s_d.pins.dout_oe = 1'b0;
            s_d.bitn = '0;
            s_d.last = CFG_I.data_size;
            s_d.rxsh = '0;
          end else begin
            s_d.st = ST_GAP;
            s_d.pins.cs_n = 1'b1;
            s_d.push = s_q.capture && buf_ready;
            // counter that reached zero frees the sequencer for the other one
            if (s_q.owner == CNT_RX && s_q.rxcnt == '0) begin
              s_d.owner = CNT_NONE;
              s_d.rx_dummy = 1'b0;
            end
            if (s_q.owner == CNT_TX && s_q.txcnt == '0) begin
              s_d.owner = CNT_NONE;
            end
          end
        end
      end
      ST_GAP: begin
        // chip select stays high for half a bit between words
        s_d.div = half_tick ? '0 : s_q.div + DIV_W'(1);
        if (half_tick) begin
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (RXCNT_WR_I) begin
      s_d.rxcnt = RXCNT_I;
    end
    if (TXCNT_WR_I) begin
      s_d.txcnt = TXCNT_I;
    end
    // a new event wins over a clear in the same cycle
    s_d.ovr = ovr_evt || (s_q.ovr && !INT_CLR_I[`ICR_OVR_BIT]);
    s_d.unr = stale || (s_q.unr && !INT_CLR_I[`ICR_UNR_BIT]);
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      s_q <= '{st: ST_IDLE, mode: MODE_FULL, owner: CNT_NONE,
               pins: '{sclk: 1'b0, cs_n: 1'b1, dout: 1'b0, dout_oe: 1'b0},
               txe: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  spi_rx_buf #(
    .W(`WORD_W)
  ) u_rx_buf (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .in_valid_i(s_q.push),
    .in_ready_o(buf_ready),
    .in_data_i(s_q.rxsh),
    .out_valid_o(RX_VALID_O),
    .out_ready_i(RX_READY_I),
    .out_data_o(RX_DATA_O)
  );

  assign RXCNT_O = s_q.rxcnt;
  assign TXCNT_O = s_q.txcnt;
  assign IRQ_SRC_O = '{rx_overrun: s_q.ovr, tx_underrun: s_q.unr, tx_empty: s_q.txe};
  assign BUSY_O = (s_q.st != ST_IDLE);
  assign PINS_O = s_q.pins;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  property p_ovr_set;
    ovr_evt |=> IRQ_SRC_O.rx_overrun && !s_q.push ##1 IRQ_SRC_O.rx_overrun;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not raised or word pushed");

  property p_unr_sticky;
    IRQ_SRC_O.tx_underrun && !INT_CLR_I[`ICR_UNR_BIT] |=> IRQ_SRC_O.tx_underrun;
  endproperty
  a_unr_sticky: assert property (p_unr_sticky) else $error("underrun lost without clear");

  property p_unr_stale;
    stale |=> IRQ_SRC_O.tx_underrun && $stable(s_q.txsh);
  endproperty
  a_unr_stale: assert property (p_unr_stale) else $error("underrun start not stale");

  property p_txe;
    TX_VALID_I |=> !IRQ_SRC_O.tx_empty;
  endproperty
  a_txe: assert property (p_txe) else $error("tx empty source with data present");

  property p_txonly_nocap;
    start && !is_three && CFG_I.transfer_mode_select == MODE_TX_ONLY |=> !s_q.capture;
  endproperty
  a_txonly_nocap: assert property (p_txonly_nocap) else $error("transmit-only captured");

  property p_rx_dec;
    drx && !RXCNT_WR_I |=> s_q.rxcnt == $past(s_q.rxcnt) - CNT_W'(1) && s_q.st == ST_SHIFT;
  endproperty
  a_rx_dec: assert property (p_rx_dec) else $error("rx counter not decremented at start");

  property p_rx_tx_nodec;
    use_tx && CFG_I.transfer_mode_select == MODE_RX_CNT && !RXCNT_WR_I |=> $stable(s_q.rxcnt);
  endproperty
  a_rx_tx_nodec: assert property (p_rx_tx_nodec) else $error("rx counted on queue word");

  property p_rx_stop;
    s_q.st == ST_IDLE && !is_three && CFG_I.transfer_mode_select == MODE_RX_CNT &&
      s_q.rxcnt == '0 && (s_q.rx_dummy || !TX_VALID_I) |-> !start;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("receive mode ran at zero count");

  property p_dummy_only;
    start && s_q.rx_dummy && CFG_I.transfer_mode_select == MODE_RX_CNT && !is_three
      |-> use_dummy && !TX_READY_O;
  endproperty
  a_dummy_only: assert property (p_dummy_only) else $error("queue word sent in dummy run");

  property p_comb_halt;
    s_q.st == ST_IDLE && !is_three && CFG_I.transfer_mode_select == MODE_COMBINED &&
      ((s_q.txcnt == '0 && s_q.rxcnt == '0) || (s_q.txcnt != '0 && !TX_VALID_I) ||
       (s_q.txcnt == '0 && TX_VALID_I)) |-> !start;
  endproperty
  a_comb_halt: assert property (p_comb_halt) else $error("combined mode ran when halted");

  property p_owner;
    s_q.owner == CNT_TX |-> !drx;
  endproperty
  a_owner: assert property (p_owner) else $error("rx count used before tx count done");

  property p_mode_hold;
    s_q.st != ST_IDLE ##1 s_q.st != ST_IDLE |-> $stable(s_q.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed inside a word");

  property p_three_oe;
    s_q.st == ST_RESP |-> !PINS_O.dout_oe && !PINS_O.cs_n;
  endproperty
  a_three_oe: assert property (p_three_oe) else $error("line driven during response");

  c_dummy_run: cover property (drx && CFG_I.transfer_mode_select == MODE_RX_CNT);
  c_overrun: cover property (ovr_evt);
  c_three_resp: cover property (s_q.st == ST_SHIFT ##1 s_q.st == ST_RESP);
  c_comb_switch: cover property (s_q.owner == CNT_TX ##[1:400] drx);
endmodule

// *** tb/spi_slave_model.sv ***
// behavioural serial slave: replies with a given word, captures what the master sends
module spi_slave_model import spi_seq_pkg::*; (
  input wire spi_pins_t pins_i,
  input wire logic [7:0] reply_i,
  output logic din_o,
  output logic [7:0] got_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx;
  logic [7:0] word;
  logic oe_q;
  initial begin
    din_o = 1'b0;
    got_o = 8'h00;
    idx = 0;
    word = 8'h00;
    oe_q = 1'b1;
  end
  // one reply word for every frame the master opens
  // latched at chip select so a reply change mid-frame cannot tear the word
  always @(negedge pins_i.cs_n) begin
    word = reply_i;
    idx = 7;
    oe_q = 1'b1;
    din_o = reply_i[7];
  end
  // one handler for both cases avoids a race between release and shift
  always @(negedge pins_i.sclk) begin
    if (!pins_i.cs_n) begin
      if (oe_q && !pins_i.dout_oe) begin
        // shared line just released: the response starts at its first bit
        idx = 7;
      end else if (idx > 0) begin
        idx--;
      end
      din_o = word[idx];
      oe_q = pins_i.dout_oe;
    end
  end
  // released line shows the inverse so a stale bit cannot pass for data
  always @(posedge pins_i.cs_n) begin
    din_o = ~din_o;
  end
  // only bits the master actually drives count as sent
  always @(posedge pins_i.sclk) begin
    if (pins_i.dout_oe) begin
      got_o = {got_o[6:0], pins_i.dout};
    end
  end
endmodule

// *** tb/spi_master_transfer_sequencer_tb_top.sv ***
// self-checking bench for the serial master transfer sequencer
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin $display("Error %s exp %0h got %0h", n, e, g); err_count++; end end
module spi_master_transfer_sequencer_tb_top import spi_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rxc_wr, txc_wr, tx_valid, tx_rdy, rx_valid, rx_rdy, busy, din, popd;
  logic [1:0] clr;
  logic [15:0] rxc_in, txc_in, rxc, txc;
  logic [31:0] dummy, tx_data, rx_data;
  logic [7:0] reply, got;
  seq_cfg_t cfg;
  irq_src_t irq;
  spi_pins_t pins;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int err_count, num_checks;
  spi_master_seq #(.CNT_W(16), .HALF_CYC(8)) u_spi_master_seq (
    .MCLK_I(clk), .RST_I(rst), .CFG_I(cfg), .DUMMY_CHAR_I(dummy),
    .RXCNT_WR_I(rxc_wr), .RXCNT_I(rxc_in), .TXCNT_WR_I(txc_wr), .TXCNT_I(txc_in),
    .INT_CLR_I(clr), .TX_VALID_I(tx_valid), .TX_DATA_I(tx_data), .TX_READY_O(tx_rdy),
    .RX_VALID_O(rx_valid), .RX_READY_I(rx_rdy), .RX_DATA_O(rx_data), .RXCNT_O(rxc),
    .TXCNT_O(txc), .IRQ_SRC_O(irq), .BUSY_O(busy), .PINS_O(pins), .DIN_I(din)
  );
  spi_slave_model u_spi_slave_model (.pins_i(pins), .reply_i(reply), .din_o(din), .got_o(got));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // tx queue: the design pops on a high ready; the slave answers with the inverse word
  always @(posedge clk) begin
    if (tx_rdy === 1'b1 && tx_valid) popd = 1'b1;
    if (rx_valid === 1'b1 && rx_rdy) rxq.push_back(rx_data[7:0]);
  end
  always @(negedge clk) begin
    if (popd) begin
      void'(txq.pop_front());
      popd = 1'b0;
    end
    // the slave latches at chip select, so the head word's answer must be ready first
    if (txq.size() > 0) begin
      reply = ~txq[0];
    end
    tx_valid = txq.size() > 0;
    tx_data = (txq.size() > 0) ? {24'h000000, txq[0]} : 32'h00000000;
  end
  task automatic push(input logic [7:0] w);
    @(negedge clk);
    #1 txq.push_back(w);
  endtask
  task automatic quiet();
    int n, t;
    n = 0;
    t = 0;
    while (n < 40 && t < 8000) begin
      @(posedge clk);
      n = (busy === 1'b0) ? n + 1 : 0;
      t++;
    end
    `CHK("idle wait", 1, (t < 8000))
  endtask
  task automatic set_mode(input xfer_mode_t m, input logic en);
    @(negedge clk);
    cfg.transfer_mode_select = m;
    cfg.port_enable = en;
  endtask
  task automatic load(input logic [15:0] r, input logic [15:0] t, input logic wr, input logic wt);
    @(negedge clk);
    rxc_in = r;
    txc_in = t;
    rxc_wr = wr;
    txc_wr = wt;
    @(negedge clk);
    rxc_wr = 1'b0;
    txc_wr = 1'b0;
  endtask
  task automatic pulse_clr(input logic [1:0] c);
    @(negedge clk);
    clr = c;
    @(negedge clk);
    clr = 2'h0;
    @(negedge clk);
  endtask
  task automatic t_reset();
    `CHK("busy", 1'b0, busy)
    `CHK("tx_empty", 1'b1, irq.tx_empty)
    `CHK("cs_n", 1'b1, pins.cs_n)
    `CHK("rx_valid", 1'b0, rx_valid)
    `CHK("rxcnt", 16'h0000, rxc)
  endtask
  task automatic t_full();
    rxq.delete();
    set_mode(MODE_FULL, 1'b0);
    push(8'h3C);
    repeat (4) @(negedge clk);
    `CHK("tx_empty pending", 1'b0, irq.tx_empty)
    set_mode(MODE_FULL, 1'b1);
    quiet();
    `CHK("full rx count", 1, rxq.size())
    `CHK("full rx word", 8'hC3, rxq[0])
    `CHK("full sent", 8'h3C, got)
    `CHK("tx_empty drained", 1'b1, irq.tx_empty)
  endtask
  task automatic t_txonly();
    rxq.delete();
    set_mode(MODE_TX_ONLY, 1'b1);
    push(8'h5A);
    quiet();
    `CHK("txonly sent", 8'h5A, got)
    `CHK("txonly rx none", 0, rxq.size())
  endtask
  task automatic t_rxcnt();
    rxq.delete();
    set_mode(MODE_RX_CNT, 1'b0);
    push(8'h11);
    load(16'h0002, 16'h0000, 1'b1, 1'b0);
    set_mode(MODE_RX_CNT, 1'b1);
    quiet();
    // pending word goes first uncounted, then two counted dummies, then a stop
    `CHK("rxcnt frames", 3, rxq.size())
    `CHK("rxcnt zero", 16'h0000, rxc)
    `CHK("rxcnt dummy", dummy[7:0], got)
    `CHK("rxcnt reply", 8'hEE, rxq[2])
    `CHK("rxcnt stopped", 1'b0, busy)
  endtask
  task automatic t_comb();
    rxq.delete();
    set_mode(MODE_COMBINED, 1'b0);
    push(8'h21);
    push(8'h42);
    load(16'h0001, 16'h0002, 1'b1, 1'b1);
    set_mode(MODE_COMBINED, 1'b1);
    quiet();
    `CHK("comb frames", 3, rxq.size())
    `CHK("comb txcnt", 16'h0000, txc)
    `CHK("comb rxcnt", 16'h0000, rxc)
    `CHK("comb dummy", dummy[7:0], got)
    `CHK("comb second", 8'hBD, rxq[1])
    load(16'h0000, 16'h0001, 1'b0, 1'b1);
    quiet();
    `CHK("comb halt empty", 3, rxq.size())
    `CHK("comb halt count", 16'h0001, txc)
  endtask
  task automatic t_overrun();
    rxq.delete();
    set_mode(MODE_FULL, 1'b0);
    @(negedge clk);
    rx_rdy = 1'b0;
    push(8'h01);
    push(8'h02);
    push(8'h03);
    set_mode(MODE_FULL, 1'b1);
    quiet();
    `CHK("overrun set", 1'b1, irq.rx_overrun)
    pulse_clr(2'h1);
    `CHK("overrun clear", 1'b0, irq.rx_overrun)
    rx_rdy = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("overrun kept", 2, rxq.size())
    `CHK("overrun first", 8'hFE, rxq[0])
    `CHK("overrun second", 8'hFD, rxq[1])
  endtask
  task automatic t_underrun();
    set_mode(MODE_FULL, 1'b1);
    cfg.keep_clocking = 1'b1;
    repeat (20) @(negedge clk);
    cfg.keep_clocking = 1'b0;
    quiet();
    `CHK("underrun set", 1'b1, irq.tx_underrun)
    repeat (10) @(negedge clk);
    `CHK("underrun sticky", 1'b1, irq.tx_underrun)
    pulse_clr(2'h2);
    `CHK("underrun clear", 1'b0, irq.tx_underrun)
  endtask
  task automatic t_three();
    rxq.delete();
    set_mode(MODE_FULL, 1'b0);
    cfg.frame_format = 2'h2;
    cfg.lsb_first = 1'b1;
    push(8'hB1);
    set_mode(MODE_FULL, 1'b1);
    quiet();
    `CHK("three sent", 8'h8D, got)
    `CHK("three frames", 1, rxq.size())
    `CHK("three reply", 8'h72, rxq[0])
    `CHK("three done", 1'b0, busy)
    `CHK("three line free", 1'b0, pins.dout_oe)
    set_mode(MODE_FULL, 1'b0);
    cfg.frame_format = 2'h0;
    cfg.lsb_first = 1'b0;
  endtask
  task automatic test_done();
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    err_count = 0;
    num_checks = 0;
    popd = 1'b0;
    rst = 1'b1;
    rxc_wr = 1'b0;
    txc_wr = 1'b0;
    rxc_in = 16'h0000;
    txc_in = 16'h0000;
    clr = 2'h0;
    rx_rdy = 1'b1;
    reply = 8'hFF;
    dummy = 32'h000000C3;
    tx_valid = 1'b0;
    tx_data = 32'h00000000;
    cfg = '{port_enable: 1'b0, master: 1'b1, transfer_mode_select: MODE_FULL,
      frame_format: 2'h0, command_size: 5'h07, data_size: 5'h07, lsb_first: 1'b0,
      keep_clocking: 1'b0};
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_full();
    t_txonly();
    t_rxcnt();
    t_comb();
    t_overrun();
    t_underrun();
    t_three();
    test_done();
  end
endmodule
